// File: common/cfid_consts.svh
// Purpose: constants of the feature identification register bank
// Assumes: included by its bare name
// Notes: field positions are low bit indexes of 4-bit fields
`ifndef CFID_CONSTS_SVH
`define CFID_CONSTS_SVH

// system register encodings, op0 op1 crn crm op2
`define CFID_OP0 2'h3
`define CFID_OP1 3'h0
`define CFID_CRN 4'h0
`define CFID_ISA_CRM 4'h6
`define CFID_ISA_OP2 3'h0
`define CFID_MMF_CRM 4'h7
`define CFID_MMF_OP2 3'h1
`define CFID_DBG_CRM 4'h1
`define CFID_DBG_OP2 3'h2

// instruction feature fields
`define CFID_CKSUM_POS 16
`define CFID_SHA256_POS 12
`define CFID_SHA160_POS 8
`define CFID_CIPHER_POS 4

// memory model fields
`define CFID_PAN_POS 20
`define CFID_LOR_POS 16
`define CFID_HPD_POS 12
`define CFID_VHE_POS 8
`define CFID_GID_POS 4
`define CFID_HWUPD_POS 0

// narrow debug fields
`define CFID_PMU_POS 24
`define CFID_MPDBG_POS 20
`define CFID_MMTRC_POS 16
`define CFID_SRTRC_POS 12
`define CFID_LMDBG_POS 8

// field codes
`define CFID_NONE 4'h0
`define CFID_ONE 4'h1
`define CFID_TWO 4'h2
`define CFID_PMU_V3_16 4'h4
`define CFID_PMU_IMPDEF 4'hF
`define CFID_GID_8 4'h0
`define CFID_GID_16 4'h2

`endif

// File: common/cfid_pkg.sv
// Purpose: types of the feature identification register bank
// Assumes: nothing
// Notes: answer kinds of a system register read
package cfid_pkg;

typedef enum logic [3:0] {
    CFID_ANS_IDLE = 4'h1,
    CFID_ANS_DATA = 4'h2,
    CFID_ANS_TRAP = 4'h4,
    CFID_ANS_UNDEF = 4'h8
} cfid_answer_t;

typedef logic [1:0] cfid_level_t;

endpackage

// File: core/cfid_regs.sv
// Purpose: read-only feature identification registers with trap and access checks
// Assumes: one system register read request at a time, sampled on mclk
// Notes: answer one cycle after the request; writes are answered as undefined
`timescale 1ns/1ns
`default_nettype none
`include "cfid_consts.svh"

// Summary of operation
// R01: instruction register bits 15:12 report 256-bit hash, 0 none, 1 present.
// R02: instruction register bits 11:8 report 160-bit hash, 0 none, 1 present.
// R03: instruction register bits 7:4 report cipher: 0, 1 rounds, 2 plus multiply.
// R04: checksum field bits 19:16 report all eight checksum instructions; later revision 1.
// R05: registers are read only through the read instruction; no write path.
// R06: decode instruction and memory model registers at their encodings.
// R07: levels 1 to 3 may read; level 0 is refused; level 1 not under host traps; level 2 is also refused when world_select_bit is clear.
// R08: guest level-1 reads trap to level 2 when the id trap bit is set.
// R09: memory model bits 23:20 report privileged-access-never; later revision 1.
// R10: memory model bits 19:16 report ordering regions; later revision 1.
// R11: memory model bits 15:12 report hierarchical permission disables.
// R12: memory model bits 11:8 report host virtualization extensions.
// R13: memory model bits 7:4 give guest id width, 0 for 8, 2 for 16.
// R14: memory model bits 3:0 give hardware access and dirty update level.
// R15: debug bits 27:24 give monitor version; later revision permits 0, 4, 15.
// R16: debug bits 23:20 microcontroller debug always read zero.
// R17: debug bits 19:16 report memory-mapped trace.
// R18: debug bits 15:12 report system register trace.
// R19: debug bits 11:8 legacy mapped debug read zero.
// R20: the 64-bit view of the debug register equals the 32-bit one.
// R21: without 32-bit state the debug register may read any value.
// R22: reserved bits read zero and ignore updates.
module cfid_regs
    import cfid_pkg::*;
#(
    parameter bit REV_LATER = 1'b1,
    parameter logic [3:0] SHA256_CODE = 4'h1,
    parameter logic [3:0] SHA160_CODE = 4'h1,
    parameter logic [3:0] CIPHER_CODE = 4'h2,
    parameter logic [3:0] CKSUM_CODE = 4'h1,
    parameter logic [3:0] GID_CODE = 4'h2,
    parameter logic [3:0] HWUPD_CODE = 4'h2,
    parameter logic [3:0] PMU_CODE = 4'h4,
    parameter logic [3:0] MMTRC_CODE = 4'h1,
    parameter logic [3:0] SRTRC_CODE = 4'h1,
    parameter bit HAS_NARROW_STATE = 1'b1,
    parameter bit HAS_LEVEL2 = 1'b1
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // system register request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_op0,
    input wire logic [2:0] req_op1,
    input wire logic [3:0] req_crn,
    input wire logic [3:0] req_crm,
    input wire logic [2:0] req_op2,
    input wire logic [1:0] req_level,
    // controls from the level-2 and level-3 configuration
    input wire logic world_select_bit,
    input wire logic host_at_level2_enable,
    input wire logic trap_general_exceptions,
    input wire logic id_read_trap_enable,
    // answer
    output logic rsp_valid,
    output logic [63:0] rsp_data,
    output logic rsp_trap_level2,
    output logic rsp_undefined
);

    logic [63:0] isa_value;
    logic [63:0] mmf_value;
    logic [31:0] dbg_value;
    logic hit_isa;
    logic hit_mmf;
    logic hit_dbg;
    logic hit_any;
    logic lvl1_na;
    logic lvl1_trap;
    logic deny;
    cfid_answer_t ans_next;
    logic [63:0] data_next;

    function automatic logic [3:0] rev_only(input logic [3:0] code);
        rev_only = REV_LATER ? code : `CFID_NONE;
    endfunction

    function automatic logic [63:0] put4(input logic [3:0] code, input int pos);
        put4 = 64'h0;
        put4[pos +: 4] = code;
    endfunction

    // fixed values; unlisted ranges stay zero and have no storage
    always_comb
    begin
        isa_value = 64'h0; // R22
        isa_value = isa_value | put4(SHA256_CODE, `CFID_SHA256_POS); // R01
        isa_value = isa_value | put4(SHA160_CODE, `CFID_SHA160_POS); // R02
        isa_value = isa_value | put4(CIPHER_CODE, `CFID_CIPHER_POS); // R03
        isa_value = isa_value | put4(REV_LATER ? `CFID_ONE : CKSUM_CODE, `CFID_CKSUM_POS); // R04
    end

    always_comb
    begin
        mmf_value = 64'h0; // R22
        mmf_value = mmf_value | put4(rev_only(`CFID_ONE), `CFID_PAN_POS); // R09
        mmf_value = mmf_value | put4(rev_only(`CFID_ONE), `CFID_LOR_POS); // R10
        mmf_value = mmf_value | put4(rev_only(`CFID_ONE), `CFID_HPD_POS); // R11
        mmf_value = mmf_value | put4(rev_only(`CFID_ONE), `CFID_VHE_POS); // R12
        mmf_value = mmf_value | put4(rev_only(GID_CODE), `CFID_GID_POS); // R13
        mmf_value = mmf_value | put4(rev_only(HWUPD_CODE), `CFID_HWUPD_POS); // R14
    end

    always_comb
    begin
        logic [3:0] pmu;
        logic [63:0] wide;
        wide = 64'h0;
        pmu = PMU_CODE;
        if (REV_LATER && (PMU_CODE != `CFID_NONE) && (PMU_CODE != `CFID_PMU_V3_16)
            && (PMU_CODE != `CFID_PMU_IMPDEF))
        begin
            pmu = `CFID_PMU_V3_16;
        end
        wide = wide | put4(pmu, `CFID_PMU_POS); // R15
        wide = wide | put4(`CFID_NONE, `CFID_MPDBG_POS); // R16
        wide = wide | put4(MMTRC_CODE, `CFID_MMTRC_POS); // R17
        wide = wide | put4(SRTRC_CODE, `CFID_SRTRC_POS); // R18
        wide = wide | put4(`CFID_NONE, `CFID_LMDBG_POS); // R19
        // without 32-bit state the contents are free; zero is chosen
        dbg_value = HAS_NARROW_STATE ? wide[31:0] : 32'h0; // R21
    end

    // encoding decode
    always_comb
    begin
        logic common;
        common = (req_op0 == `CFID_OP0) && (req_op1 == `CFID_OP1) && (req_crn == `CFID_CRN);
        hit_isa = common && (req_crm == `CFID_ISA_CRM) && (req_op2 == `CFID_ISA_OP2); // R06
        hit_mmf = common && (req_crm == `CFID_MMF_CRM) && (req_op2 == `CFID_MMF_OP2); // R06
        hit_dbg = common && (req_crm == `CFID_DBG_CRM) && (req_op2 == `CFID_DBG_OP2);
        hit_any = hit_isa || hit_mmf || hit_dbg;
    end

    // access permission and trapping
    always_comb
    begin
        lvl1_na = world_select_bit && trap_general_exceptions; // R07
        lvl1_trap = HAS_LEVEL2 && world_select_bit && id_read_trap_enable
            && (!host_at_level2_enable || !trap_general_exceptions); // R08
        deny = (req_level == 2'h0) || ((req_level == 2'h1) && lvl1_na)
            || ((req_level == 2'h2) && !world_select_bit); // R07
    end

    always_comb
    begin
        ans_next = CFID_ANS_IDLE;
        data_next = 64'h0;
        if (req_valid)
        begin
            if (!hit_any || req_write || deny) // R05
            begin
                ans_next = CFID_ANS_UNDEF;
            end
            else if ((req_level == 2'h1) && lvl1_trap)
            begin
                ans_next = CFID_ANS_TRAP; // R08
            end
            else
            begin
                ans_next = CFID_ANS_DATA;
                if (hit_isa)
                begin
                    data_next = isa_value;
                end
                else if (hit_mmf)
                begin
                    data_next = mmf_value;
                end
                else
                begin
                    data_next = {32'h0, dbg_value}; // R20
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rsp_valid <= 1'b0;
            rsp_trap_level2 <= 1'b0;
            rsp_undefined <= 1'b0;
            rsp_data <= 64'h0;
        end
        else
        begin
            rsp_valid <= req_valid;
            rsp_trap_level2 <= (ans_next == CFID_ANS_TRAP);
            rsp_undefined <= (ans_next == CFID_ANS_UNDEF);
            rsp_data <= data_next;
        end
    end

endmodule
`default_nettype wire

// File: tb/cfid_regs_properties.sv
// Purpose: answer port assertions
// Assumes: one clock, async reset
// Notes: bound to cfid_regs
`timescale 1ns/1ns
`default_nettype none
module cfid_regs_properties (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_op0,
    input wire logic [2:0] req_op1,
    input wire logic [3:0] req_crn,
    input wire logic [3:0] req_crm,
    input wire logic [2:0] req_op2,
    input wire logic [1:0] req_level,
    input wire logic world_select_bit,
    input wire logic trap_general_exceptions,
    input wire logic id_read_trap_enable,
    // answer
    input wire logic rsp_valid,
    input wire logic [63:0] rsp_data,
    input wire logic rsp_trap_level2,
    input wire logic rsp_undefined
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    wire logic base_ok = {req_op0, req_op1, req_crn} == 9'h180;
    sequence s_rd(lvl, enc);
        req_valid && !req_write && base_ok && req_level == lvl && {req_crm, req_op2} == enc;
    endsequence
    sequence s_ans(v);
        rsp_valid && !rsp_undefined && !rsp_trap_level2 && rsp_data == v;
    endsequence
    property p_isa;
        s_rd(2'h3, 7'h30) |=> s_ans(64'h11120);
    endproperty
    a_isa: assert property (p_isa) else $error("isa value");
    property p_mmf;
        s_rd(2'h3, 7'h39) |=> s_ans(64'h111122);
    endproperty
    a_mmf: assert property (p_mmf) else $error("mmf value");
    property p_dbg;
        s_rd(2'h3, 7'h0A) |=> s_ans(64'h4011000);
    endproperty
    a_dbg: assert property (p_dbg) else $error("dbg value");
    property p_refuse;
        req_valid && (req_write || req_level == 2'h0) |=> rsp_undefined && rsp_data == 64'h0;
    endproperty
    a_refuse: assert property (p_refuse) else $error("not refused");
    property p_trap;
        s_rd(2'h1, 7'h30) ##0 (world_select_bit && id_read_trap_enable && !trap_general_exceptions)
            |=> rsp_trap_level2 && !rsp_undefined;
    endproperty
    a_trap: assert property (p_trap) else $error("no trap");
    property p_unmapped;
        req_valid && {req_crm, req_op2} == 7'h31 |=> rsp_undefined;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_once;
        req_valid |=> rsp_valid;
    endproperty
    a_once: assert property (p_once) else $error("no answer");
    property p_quiet;
        !req_valid |=> !rsp_valid && !rsp_trap_level2 && !rsp_undefined && rsp_data == 64'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray answer");
endmodule
bind cfid_regs cfid_regs_properties chk_u (.*);
`default_nettype wire

// File: tb/cfid_regs_test.sv
// Purpose: random test of cfid_regs
// Assumes: answer one cycle after request
// Notes: driver queues expected answers
`timescale 1ns/1ns
`default_nettype none
module cfid_regs_test;
    logic mclk, sys_rst, req_valid, req_write, rsp_valid, rsp_trap_level2, rsp_undefined;
    logic world_select_bit, host_at_level2_enable, trap_general_exceptions, id_read_trap_enable;
    logic [1:0] req_op0, req_level, a;
    logic [2:0] req_op1, req_op2;
    logic [3:0] req_crn, req_crm;
    logic [63:0] rsp_data, d;
    logic [66:0] seen, exp_q[$];
    logic [15:0] enc;
    logic [6:0] tbl[4] = '{7'h30, 7'h39, 7'h0A, 7'h31};
    logic [5:0] cfg;
    logic v, wr;
    int failures = 0;
    int cmp_count = 0;
    int k;
    cfid_regs dut_u (.*);
    assign seen = {rsp_valid, rsp_trap_level2, rsp_undefined, rsp_data};
    task automatic check(input logic [66:0] got, input logic [66:0] want);
        cmp_count++;
        if (got !== want)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, got, want);
        end
    endtask
    task automatic finish_test();
        $display("failures=%0d compares=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // level field is cfg[1:0]; secure select, host, general trap, id trap above it
    task automatic drive(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            enc = $urandom;
            cfg = $urandom;
            k = $urandom % 5;
            if (k < 4)
                enc = {9'h180, tbl[k]};
            v = $urandom % 4 != 0;
            wr = $urandom % 8 == 0;
            d = enc == 16'hC030 ? 64'h11120 :
                enc == 16'hC039 ? 64'h111122 :
                enc == 16'hC00A ? 64'h4011000 : 64'h0;
            a = wr || d == 0 || cfg[1:0] == 0 || cfg[1:0] == 1 && cfg[5] && cfg[3]
                || cfg[1:0] == 2 && !cfg[5] ? 2'h1 :
                cfg[1:0] == 1 && cfg[5] && cfg[2] ? 2'h2 : 2'h0;
            req_valid <= v;
            req_write <= wr;
            {req_op0, req_op1, req_crn, req_crm, req_op2} <= enc;
            {world_select_bit, host_at_level2_enable, trap_general_exceptions,
                id_read_trap_enable, req_level} <= cfg;
            if (v)
                exp_q.push_back({1'b1, a, a == 0 ? d : 64'h0});
        end
        @(posedge mclk);
        req_valid <= 1'b0;
    endtask
    always @(negedge mclk)
        if (rsp_valid === 1'b1 && exp_q.size() > 0)
            check(seen, exp_q.pop_front());
        else
            check(seen, 67'h0);
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        sys_rst = 1'b1;
        {req_valid, req_write, req_op0, req_op1, req_crn, req_crm, req_op2} = 18'h0;
        {world_select_bit, host_at_level2_enable, trap_general_exceptions} = 3'h0;
        {id_read_trap_enable, req_level} = 3'h0;
        k = $urandom(32'hC95B);
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        drive(600);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        drive(600);
        for (k = 0; k < 10 && exp_q.size() > 0; k++)
            @(posedge mclk);
        check(67'(exp_q.size()), 67'h0);
        finish_test();
    end
endmodule
`default_nettype wire
